// *** core/partial_display_color_select.sv ***
// module: partial display area and non-display colour selection with gamma set holding
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module partial_display_color_select
  import partial_display_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic [11:0]                s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  input  wire logic                       s_axi_awvalid,
  output var  logic                       s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output var  logic                       s_axi_wready,
  output var  logic [1:0]                 s_axi_bresp,
  output var  logic                       s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [11:0]                s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  input  wire logic                       s_axi_arvalid,
  output var  logic                       s_axi_arready,
  output var  logic [31:0]                s_axi_rdata,
  output var  logic [1:0]                 s_axi_rresp,
  output var  logic                       s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic [7:0]                 row_index,
  input  wire logic                       pix_valid,
  input  wire partial_display_pkg::pixel_t pix_in,
  input  wire logic                       drive_negative,
  output var  partial_display_pkg::pixel_t level_out,
  output var  logic                       level_valid,
  output var  logic                       mid_levels_en,
  output var  logic                       gamma_active,
  output var  partial_display_pkg::gamma_set_t gamma_out
);
  import partial_display_pkg::*;

  chan_state_t w_state_q;        // write channel state
  chan_state_t r_state_q;        // read channel state
  logic [7:0]  ctrl_q;           // first_control_register
  logic [7:0]  off_src_q;        // off_area_source_select
  logic [7:0]  off_color_q;      // off_area_fixed_color
  logic [7:0]  a1_start_q;       // area1_start_field
  logic [7:0]  a2_start_q;       // area2_start_field
  logic [7:0]  a1_count_q;       // area1_height_field
  logic [7:0]  a2_count_q;       // area2_height_field
  logic [7:0]  gam_q [GAMMA_REGS]; // gamma registers, positive set first
  logic        wr_go;            // write takes effect this edge
  logic        wr_lane;          // low byte lane enabled
  logic        wr_hit;           // write address is mapped
  logic        rd_hit;           // read address is mapped
  logic [7:0]  rd_byte;          // read data, low byte
  logic [3:0]  rd_gidx;          // gamma index of read address
  logic [8:0]  row9;             // row index widened for compare
  logic [8:0]  a1_first;         // first row of area one
  logic [8:0]  a1_last;          // last row of area one
  logic [8:0]  a2_first;         // first row of area two
  logic [8:0]  a2_last;          // last row of area two
  logic        in_a1;            // row inside area one
  logic        in_a2;            // row inside area two
  logic        disp_row;         // row shows frame data
  logic        partial_en;       // partial_mode_enable
  logic        reduced_en;       // reduced colour mode
  pixel_t      level_d;          // next sub-pixel levels
  gamma_set_t  pos_set;          // decoded positive gamma set
  gamma_set_t  neg_set;          // decoded negative gamma set

  // one bit to an extreme level
  function automatic logic [5:0] extreme(input logic b);
    return b ? LEVEL_HIGH : LEVEL_LOW;
  endfunction

  // decode six gamma registers into ladder weights
  function automatic gamma_set_t decode_set(input logic [7:0] amp_hi, input logic [7:0] amp_lo,
                                            input logic [7:0] f10, input logic [7:0] f32,
                                            input logic [7:0] f54, input logic [7:0] grad);
    gamma_set_t s;
    logic [17:0] codes;
    codes = {f54[FIELD_HI_LSB +: 3], f54[FIELD_LO_LSB +: 3], f32[FIELD_HI_LSB +: 3],
             f32[FIELD_LO_LSB +: 3], f10[FIELD_HI_LSB +: 3], f10[FIELD_LO_LSB +: 3]};
    s.upper_amp_w  = 6'(amp_hi[5:0] * AMP_UNIT);
    s.lower_amp_w  = 6'(amp_lo[5:0] * AMP_UNIT);
    s.upper_grad_w = 5'(grad[FIELD_LO_LSB +: 3] * GRAD_UNIT);
    s.lower_grad_w = 5'(grad[FIELD_HI_LSB +: 3] * GRAD_UNIT);
    for (int k = 0; k < 6; k++) begin
      s.tap_offsets[3*k +: 3] = TAP_TOP - codes[3*k +: 3];
    end
    return s;
  endfunction

  assign wr_go      = (w_state_q == CH_TAKE);
  assign wr_lane    = s_axi_wstrb[0];
  assign partial_en = ctrl_q[PARTIAL_BIT];
  assign reduced_en = ctrl_q[REDUCED_BIT];
  assign rd_gidx    = 4'((s_axi_araddr - ADDR_GAMMA0) >> 2);

  // write address decode
  always_comb begin
    if (s_axi_awaddr[1:0] != 2'h0) begin
      wr_hit = 1'b0;
    end else if (s_axi_awaddr == ADDR_CTRL || s_axi_awaddr == ADDR_OFF_SRC) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr >= ADDR_OFF_COLOR && s_axi_awaddr <= ADDR_A2_COUNT) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr >= ADDR_GAMMA0 && s_axi_awaddr <= ADDR_GAMMA_END) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // read address decode and data mux
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    if (s_axi_araddr[1:0] != 2'h0) begin
      rd_hit = 1'b0;
    end else if (s_axi_araddr == ADDR_CTRL) begin
      rd_byte = ctrl_q;
    end else if (s_axi_araddr == ADDR_OFF_SRC) begin
      rd_byte = off_src_q;
    end else if (s_axi_araddr == ADDR_OFF_COLOR) begin
      rd_byte = off_color_q;
    end else if (s_axi_araddr == ADDR_A1_START) begin
      rd_byte = a1_start_q;
    end else if (s_axi_araddr == ADDR_A2_START) begin
      rd_byte = a2_start_q;
    end else if (s_axi_araddr == ADDR_A1_COUNT) begin
      rd_byte = a1_count_q;
    end else if (s_axi_araddr == ADDR_A2_COUNT) begin
      rd_byte = a2_count_q;
    end else if (s_axi_araddr >= ADDR_GAMMA0 && s_axi_araddr <= ADDR_GAMMA_END) begin
      rd_byte = gam_q[rd_gidx];
    end else begin
      rd_hit = 1'b0;
    end
  end

  // write channel: address and data taken together, then response
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      w_state_q     <= CH_IDLE;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else if (ce) begin
      case (w_state_q)
        CH_IDLE: begin
          // both valids present: open both readies for one cycle
          if (s_axi_awvalid && s_axi_wvalid) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            w_state_q     <= CH_TAKE;
          end
        end
        CH_TAKE: begin
          // handshake edge: store and answer
          s_axi_awready <= 1'b0;
          s_axi_wready  <= 1'b0;
          s_axi_bvalid  <= 1'b1;
          s_axi_bresp   <= wr_hit ? RESP_OKAY : RESP_DECERR;
          w_state_q     <= CH_RESP;
        end
        CH_RESP: begin
          // hold response until taken
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            w_state_q    <= CH_IDLE;
          end
        end
        default: w_state_q <= CH_IDLE;
      endcase
    end
  end

  // read channel: address taken, data one cycle later
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r_state_q     <= CH_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      case (r_state_q)
        CH_IDLE: begin
          if (s_axi_arvalid) begin
            s_axi_arready <= 1'b1;
            r_state_q     <= CH_TAKE;
          end
        end
        CH_TAKE: begin
          // unused upper bits read as zero
          s_axi_arready <= 1'b0;
          s_axi_rvalid  <= 1'b1;
          s_axi_rdata   <= {24'h00_0000, rd_byte};
          s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_DECERR;
          r_state_q     <= CH_RESP;
        end
        CH_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            r_state_q    <= CH_IDLE;
          end
        end
        default: r_state_q <= CH_IDLE;
      endcase
    end
  end

  // mode and partial area registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q      <= CTRL_RST;
      off_src_q   <= PARTIAL_RST;
      off_color_q <= PARTIAL_RST;
      a1_start_q  <= PARTIAL_RST;
      a2_start_q  <= PARTIAL_RST;
      a1_count_q  <= PARTIAL_RST;
      a2_count_q  <= PARTIAL_RST;
    end else if (ce && wr_go && wr_lane) begin
      if (s_axi_awaddr == ADDR_CTRL) begin
        ctrl_q <= s_axi_wdata[7:0];
      end else if (s_axi_awaddr == ADDR_OFF_SRC) begin
        off_src_q <= s_axi_wdata[7:0];
      end else if (s_axi_awaddr == ADDR_OFF_COLOR) begin
        off_color_q <= s_axi_wdata[7:0];
      end else if (s_axi_awaddr == ADDR_A1_START) begin
        a1_start_q <= s_axi_wdata[7:0];
      end else if (s_axi_awaddr == ADDR_A2_START) begin
        a2_start_q <= s_axi_wdata[7:0];
      end else if (s_axi_awaddr == ADDR_A1_COUNT) begin
        a1_count_q <= s_axi_wdata[7:0];
      end else if (s_axi_awaddr == ADDR_A2_COUNT) begin
        a2_count_q <= s_axi_wdata[7:0];
      end
    end
  end

  // gamma registers, written only by software, untouched by modes
  for (genvar gi = 0; gi < GAMMA_REGS; gi++) begin : g_gamma
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        gam_q[gi] <= GAMMA_RST[gi*8 +: 8];
      end else if (ce && wr_go && wr_lane && s_axi_awaddr == ADDR_GAMMA0 + 12'(4*gi)) begin
        gam_q[gi] <= s_axi_wdata[7:0];
      end
    end
  end

  // area ranges: rows start+1 through start+count
  assign row9     = {1'b0, row_index};
  assign a1_first = {1'b0, a1_start_q} + 9'h001;
  assign a2_first = {1'b0, a2_start_q} + 9'h001;
  assign a1_last  = {1'b0, a1_start_q} + {1'b0, a1_count_q};
  assign a2_last  = {1'b0, a2_start_q} + {1'b0, a2_count_q};
  // overlapping areas are left to software; either hit shows data
  assign in_a1    = (row9 >= a1_first) && (row9 <= a1_last);
  assign in_a2    = (row9 >= a2_first) && (row9 <= a2_last);
  assign disp_row = !partial_en || in_a1 || in_a2;

  // sub-pixel level selection
  always_comb begin
    if (disp_row && !reduced_en) begin
      level_d = pix_in;
    end else if (disp_row || off_src_q[OFF_SRC_BIT]) begin
      // reduced colour or off rows from data: msb picks the extreme
      level_d.red   = extreme(pix_in.red[5]);
      level_d.green = extreme(pix_in.green[5]);
      level_d.blue  = extreme(pix_in.blue[5]);
    end else begin
      // off rows show the fixed colour code
      level_d.red   = extreme(off_color_q[OFF_RED_BIT]);
      level_d.green = extreme(off_color_q[OFF_GREEN_BIT]);
      level_d.blue  = extreme(off_color_q[OFF_BLUE_BIT]);
    end
  end

  // pixel output stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level_out   <= '0;
      level_valid <= 1'b0;
    end else if (ce) begin
      level_valid <= pix_valid;
      if (pix_valid) begin
        level_out <= level_d;
      end
    end
  end

  assign pos_set = decode_set(gam_q[0], gam_q[1], gam_q[2], gam_q[3], gam_q[4], gam_q[5]);
  assign neg_set = decode_set(gam_q[NEG_SET_BASE], gam_q[NEG_SET_BASE+1], gam_q[NEG_SET_BASE+2],
                              gam_q[NEG_SET_BASE+3], gam_q[NEG_SET_BASE+4],
                              gam_q[NEG_SET_BASE+5]);

  // ladder control: polarity set, intermediate levels off in reduced mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gamma_out     <= '0;
      mid_levels_en <= 1'b0;
      gamma_active  <= 1'b0;
    end else if (ce) begin
      gamma_out     <= drive_negative ? neg_set : pos_set;
      mid_levels_en <= !reduced_en;
      gamma_active  <= !reduced_en;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_write_taken;
    ce && w_state_q == CH_TAKE;
  endsequence

  sequence s_resp_waiting;
    s_axi_bvalid && !(ce && s_axi_bready);
  endsequence

  a_reduced_extremes: assert property (ce && pix_valid && reduced_en |=>
    level_out.red[4:0] == {5{level_out.red[5]}} && level_out.blue[4:0] == {5{level_out.blue[5]}})
    else $error("reduced colour level not extreme");
  a_mid_off: assert property (ce && reduced_en |=> !mid_levels_en && !gamma_active)
    else $error("intermediate levels still enabled");
  a_gamma_kept: assert property (!(ce && wr_go) |=>
    $stable(gam_q[0]) && $stable(gam_q[11]))
    else $error("gamma register changed without a write");
  a_area_start: assert property (ce && pix_valid && partial_en && !reduced_en
    && row9 == a1_first && a1_count_q != 8'h00 |=> level_out == $past(pix_in))
    else $error("area first row not shown from data");
  a_area_end: assert property (ce && pix_valid && partial_en && !in_a2
    && row9 == a1_last + 9'h001 && !off_src_q[OFF_SRC_BIT] |=>
    level_out.blue == extreme($past(off_color_q[OFF_BLUE_BIT])))
    else $error("row after area end not off colour");
  a_off_fixed: assert property (ce && pix_valid && !disp_row
    && !off_src_q[OFF_SRC_BIT] |=>
    level_out.red == ($past(off_color_q[OFF_RED_BIT]) ? LEVEL_HIGH : LEVEL_LOW))
    else $error("fixed red level wrong");
  a_off_msb: assert property (ce && pix_valid && !disp_row
    && off_src_q[OFF_SRC_BIT] |=>
    level_out.green == ($past(pix_in.green[5]) ? LEVEL_HIGH : LEVEL_LOW))
    else $error("off row msb level wrong");
  a_fine_tap: assert property (ce && !drive_negative |=>
    gamma_out.tap_offsets[2:0] == TAP_TOP - $past(gam_q[2][2:0]))
    else $error("fine tap offset wrong");
  a_grad_weight: assert property (ce && !drive_negative |=>
    gamma_out.lower_grad_w == {$past(gam_q[5][6:4]), 2'b00})
    else $error("gradient weight not four per step");
  a_neg_set: assert property (ce && drive_negative |=>
    gamma_out.upper_amp_w == $past(gam_q[NEG_SET_BASE][5:0]))
    else $error("negative set not applied");
  a_write_resp: assert property (s_write_taken |=> s_axi_bvalid && !s_axi_awready)
    else $error("write not answered");
  a_resp_hold: assert property (s_resp_waiting |=> s_axi_bvalid)
    else $error("write response dropped early");
endmodule
`default_nettype wire

// *** core/partial_display_pkg.sv ***
// package: register map, field layout, reset values and types of the display colour select block
// What this block does
// - reduced colour drives only the two extreme levels
// - reduced colour ignores gamma but keeps gamma settings
// - partial mode shows one or two areas
// - area first row is start value plus one
// - area height comes from its count register
// - off rows show fixed colour or data msb
// - fixed colour bits pick lowest or highest level
// - fine code seven is top tap, zero lowest
// - gradient weighs four units, amplitude one unit
// - separate gamma sets for positive and negative drive
`default_nettype none
package partial_display_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CTRL        = 8'h00;  // first_control_register
  localparam logic [7:0]  IDX_OFF_SRC     = 8'h12;  // off_area_source_select
  localparam logic [7:0]  IDX_OFF_COLOR   = 8'h13;  // off_area_fixed_color
  localparam logic [7:0]  IDX_A1_START    = 8'h14;  // area_one_start_row
  localparam logic [7:0]  IDX_A2_START    = 8'h15;  // area_two_start_row
  localparam logic [7:0]  IDX_A1_COUNT    = 8'h16;  // area_one_row_count
  localparam logic [7:0]  IDX_A2_COUNT    = 8'h17;  // area_two_row_count
  localparam logic [7:0]  IDX_GAMMA_FIRST = 8'h8f;  // first gamma register
  localparam logic [7:0]  IDX_GAMMA_LAST  = 8'h9a;  // last gamma register
  localparam int          GAMMA_REGS      = 12;     // six positive then six negative
  localparam int          NEG_SET_BASE    = 6;      // first negative gamma register
  // byte addresses
  localparam logic [11:0] ADDR_CTRL       = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_OFF_SRC    = {2'h0, IDX_OFF_SRC, 2'h0};
  localparam logic [11:0] ADDR_OFF_COLOR  = {2'h0, IDX_OFF_COLOR, 2'h0};
  localparam logic [11:0] ADDR_A1_START   = {2'h0, IDX_A1_START, 2'h0};
  localparam logic [11:0] ADDR_A2_START   = {2'h0, IDX_A2_START, 2'h0};
  localparam logic [11:0] ADDR_A1_COUNT   = {2'h0, IDX_A1_COUNT, 2'h0};
  localparam logic [11:0] ADDR_A2_COUNT   = {2'h0, IDX_A2_COUNT, 2'h0};
  localparam logic [11:0] ADDR_GAMMA0     = {2'h0, IDX_GAMMA_FIRST, 2'h0};
  localparam logic [11:0] ADDR_GAMMA_END  = {2'h0, IDX_GAMMA_LAST, 2'h0};
  // field positions
  localparam int          REDUCED_BIT     = 2;      // reduced colour enable
  localparam int          PARTIAL_BIT     = 4;      // partial_mode_enable
  localparam int          OFF_SRC_BIT     = 0;      // off-row source select
  localparam int          OFF_RED_BIT     = 2;      // off_red_level
  localparam int          OFF_GREEN_BIT   = 1;      // off_green_level
  localparam int          OFF_BLUE_BIT    = 0;      // off_blue_level
  localparam int          FIELD_HI_LSB    = 4;      // odd fine tap / lower gradient
  localparam int          FIELD_LO_LSB    = 0;      // even fine tap / upper gradient
  // reset values
  localparam logic [7:0]  CTRL_RST        = 8'h00;
  localparam logic [7:0]  PARTIAL_RST     = 8'h00;
  localparam logic [95:0] GAMMA_RST       = 96'h33444444050533444444_0505;
  // ladder weights and levels
  localparam int          GRAD_UNIT       = 4;      // units per gradient code step
  localparam int          AMP_UNIT        = 1;      // units per amplitude code step
  localparam logic [2:0]  TAP_TOP         = 3'h7;   // code of tap nearest upper end
  localparam logic [5:0]  LEVEL_LOW       = 6'h00;  // lowest-index level
  localparam logic [5:0]  LEVEL_HIGH      = 6'h3f;  // highest-index level
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_DECERR     = 2'h3;

  // one pixel, three sub-pixel level indices
  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } pixel_t;

  // ladder setting of the active drive polarity
  typedef struct packed {
    logic [5:0]  upper_amp_w;   // upper amplitude weight, units
    logic [5:0]  lower_amp_w;   // lower amplitude weight, units
    logic [4:0]  upper_grad_w;  // upper gradient weight, units
    logic [4:0]  lower_grad_w;  // lower gradient weight, units
    logic [17:0] tap_offsets;   // six taps, unit steps below group top
  } gamma_set_t;

  // bus channel states
  typedef enum logic [2:0] {
    CH_IDLE = 3'b001,
    CH_TAKE = 3'b010,
    CH_RESP = 3'b100
  } chan_state_t;
endpackage
`default_nettype wire

// *** tb/testbench.sv ***
// testbench: register bus, gamma set holding and partial display level checks
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import partial_display_pkg::*;
  logic        clock = 0, rst = 1, ce = 1, awv = 0, wv = 0, bry = 0;
  logic        arv = 0, rry = 0, pv = 0, neg = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [7:0]  row = 0;
  pixel_t      pin = '0;
  logic        awr, wrdy, bv, arr, rv, mid, gact, lv;
  logic [1:0]  br, rr;
  logic [31:0] rd;
  pixel_t      lo;
  gamma_set_t  go;
  int          errors = 0, checks = 0, seed = 68;
  pixel_t      exq[$];                     // expected pixel levels, oldest first
  logic [7:0]  c0, sr, co, s1, n1, s2, n2;   // shadow copies of written registers
  logic [7:0]  gr[6] = '{8'h05, 8'h05, 8'h44, 8'h44, 8'h44, 8'h33};
  int          rows[8] = '{10, 11, 15, 16, 30, 31, 45, 46};

  // free running clock, 50 ns period
  always #25 clock = ~clock;

  partial_display_color_select partial_display_color_select_inst (
    .clock(clock), .rst(rst), .ce(ce), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .row_index(row), .pix_valid(pv), .pix_in(pin),
    .drive_negative(neg), .level_out(lo), .level_valid(lv), .mid_levels_en(mid),
    .gamma_active(gact), .gamma_out(go));

  // count a comparison and report a mismatch
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  // print the counts and the verdict, then stop
  task automatic complete_run;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one register write, waits for the response
  task automatic bus_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
    int n;
    n = 0;
    @(posedge clock);
    awa <= a; wd <= {24'h0, d}; awv <= 1; wv <= 1; bry <= 1;
    do begin
      @(posedge clock);
      n++;
      if (awr === 1'b1) awv <= 0;
      if (wrdy === 1'b1) wv <= 0;
    end while (bv !== 1'b1 && n < 200);
    bry <= 0;
    chk(n < 200 && br === e, "write response");
    if (n >= 200) complete_run;
  endtask

  // one register read, compares data and response
  task automatic bus_rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
    int n;
    n = 0;
    @(posedge clock);
    ara <= a; arv <= 1; rry <= 1;
    do begin
      @(posedge clock);
      n++;
      if (arr === 1'b1) arv <= 0;
    end while (rv !== 1'b1 && n < 200);
    rry <= 0;
    chk(n < 200 && rd === {24'h0, d} && rr === e, "read data");
    if (n >= 200) complete_run;
  endtask

  // program control and all partial registers, keeping shadows
  task automatic cfg(input logic [7:0] c, s, k, a, b, x, y);
    c0 = c; sr = s; co = k; s1 = a; n1 = b; s2 = x; n2 = y;
    bus_wr(ADDR_CTRL, c, RESP_OKAY);
    bus_wr(ADDR_OFF_SRC, s, RESP_OKAY);
    bus_wr(ADDR_OFF_COLOR, k, RESP_OKAY);
    bus_wr(ADDR_A1_START, a, RESP_OKAY);
    bus_wr(ADDR_A1_COUNT, b, RESP_OKAY);
    bus_wr(ADDR_A2_START, x, RESP_OKAY);
    bus_wr(ADDR_A2_COUNT, y, RESP_OKAY);
  endtask

  // expected levels of one pixel on a given row
  function automatic pixel_t expect_px(input logic [7:0] r, input pixel_t p);
    logic   in1, in2, disp;
    pixel_t m, f;
    in1 = {1'b0, r} >= {1'b0, s1} + 9'd1 && {1'b0, r} <= {1'b0, s1} + {1'b0, n1};
    in2 = {1'b0, r} >= {1'b0, s2} + 9'd1 && {1'b0, r} <= {1'b0, s2} + {1'b0, n2};
    disp = !c0[PARTIAL_BIT] || in1 || in2;
    m.red = p.red[5] ? LEVEL_HIGH : LEVEL_LOW;
    m.green = p.green[5] ? LEVEL_HIGH : LEVEL_LOW;
    m.blue = p.blue[5] ? LEVEL_HIGH : LEVEL_LOW;
    f.red = co[2] ? LEVEL_HIGH : LEVEL_LOW;
    f.green = co[1] ? LEVEL_HIGH : LEVEL_LOW;
    f.blue = co[0] ? LEVEL_HIGH : LEVEL_LOW;
    if (disp && !c0[REDUCED_BIT]) return p;
    if (disp || sr[0]) return m;
    return f;
  endfunction

  // drive one random pixel and note its expected levels
  task automatic px(input logic [7:0] r);
    pixel_t p;
    p = 18'($random(seed));
    row <= r; pin <= p; pv <= 1;
    exq.push_back(expect_px(r, p));
    @(posedge clock);
  endtask

  // watch the pixel outputs and compare with the oldest note
  always @(posedge clock) begin
    if (lv === 1'b1) begin
      if (exq.size() == 0) chk(1'b0, "unexpected pixel");
      else chk(lo === exq.pop_front(), "pixel level");
    end
  end

  // run length guard
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    complete_run;
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst <= 0;
    bus_rd(ADDR_CTRL, CTRL_RST, RESP_OKAY);
    for (int i = 0; i < 12; i++)
      bus_rd(ADDR_GAMMA0 + 12'(4 * i), gr[i % 6], RESP_OKAY);
    bus_rd(12'h100, 8'h00, RESP_DECERR);
    bus_rd(ADDR_A1_START + 12'h1, 8'h00, RESP_DECERR);
    bus_wr(12'h100, 8'h5a, RESP_DECERR);
    chk(go === {6'd5, 6'd5, 5'd12, 5'd12, 18'o333333}, "positive set");
    bus_wr(12'h254, 8'h1f, RESP_OKAY);
    bus_wr(12'h25c, 8'h70, RESP_OKAY);
    bus_wr(12'h268, 8'h52, RESP_OKAY);
    chk(go === {6'd5, 6'd5, 5'd12, 5'd12, 18'o333333}, "positive kept");
    neg <= 1;
    repeat (2) @(posedge clock);
    chk(go === {6'd31, 6'd5, 5'd8, 5'd20, 18'o333307}, "negative set");
    for (int k = 0; k < 34; k++) begin
      cfg(k > 31 ? 8'(k[0] ? 8'h04 : 8'h00) : (k[4] ? 8'h14 : 8'h10), 8'(k[3]), 8'(k[2:0]),
          8'd10, 8'd5, 8'd45, 8'(k[0]));
      chk(mid === !c0[REDUCED_BIT] && gact === !c0[REDUCED_BIT], "mid levels");
      foreach (rows[i]) px(8'(rows[i]));
      px(8'($random(seed)));
      pv <= 0;
      repeat (2) @(posedge clock);
    end
    bus_rd(12'h254, 8'h1f, RESP_OKAY);
    chk(exq.size() == 0, "pixels outstanding");
    complete_run;
  end
endmodule
`default_nettype wire
